// >>> src/dsi_cfg.svh
// Holds the register offsets, field reset values and counts of the sample input port.
// Assumes inclusion by bare name wherever a number of the block is needed.
`ifndef DSI_CFG_SVH
`define DSI_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DSI_ADDR_W      4
`define DSI_REG_CTRL    4'h0
`define DSI_REG_STATUS  4'h4
`define DSI_REG_DIV     4'h8

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define DSI_CTRL_RST    11'h784
`define DSI_CTRL_W      11
`define DSI_DIV_RST     8'h04
`define DSI_DIV_W       8
`define DSI_OVF_BIT     2

// ****************************************************************
// Sizes
// ****************************************************************
`define DSI_SAMPLE_W    16
`define DSI_FIFO_DEPTH  16
`define DSI_LEVEL_W     5

`endif

// >>> src/dsi_pkg.sv
// Holds the types shared by the sample input port and its FIFO.
// Assumes dsi_cfg.svh is on the include path.
`include "dsi_cfg.svh"

package dsi_pkg;

	// Clock source modes; the fourth code of the field is illegal.
	typedef enum logic [1:0] {DSI_MODE_PLL, DSI_MODE_EXT, DSI_MODE_DUAL} dsi_mode_t;

	// Control register fields, most significant first.
	typedef struct packed {
		logic      sync_fifo;
		logic      sync_div;
		logic      sync_mix;
		logic      sync_nco;
		logic      lock_clk_sel;
		logic      marker_en;
		logic      b_rev;
		logic      a_rev;
		logic      fifo_en;
		dsi_mode_t mode;
	} dsi_ctrl_t;

	// One captured sample pair with its B-sample marker.
	typedef struct packed {
		logic                       marker;
		logic [`DSI_SAMPLE_W-1:0]   b;
		logic [`DSI_SAMPLE_W-1:0]   a;
	} dsi_sample_t;

	// Pins that arrive from outside the clock domain.
	typedef struct packed {
		logic                       ir_p;
		logic                       ir_n;
		logic                       sc_p;
		logic                       sc_n;
		logic                       sync;
		logic                       lock;
		logic                       marker;
		logic [`DSI_SAMPLE_W-1:0]   a;
		logic [`DSI_SAMPLE_W-1:0]   b;
	} dsi_pins_t;

endpackage

// >>> src/dsi_fifo.sv
// Holds a first-in first-out buffer with a registered output word.
// Assumes one clock and a synchronous active-low reset; flush empties it at once.
`timescale 1ns/1ns
`include "dsi_cfg.svh"

module dsi_fifo
	import dsi_pkg::*;
#(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
)
(
	input  wire logic               clock_in,     // System clock.
	input  wire logic               rst_n_in,     // Synchronous reset, active low.
	input  wire logic               flush_in,     // Empties the buffer.
	input  wire logic               in_valid_in,  // Word offered.
	output logic                    in_ready_out, // Room for a word.
	input  wire logic [WIDTH-1:0]   in_data_in,   // Word written.
	output logic                    out_valid_out,// Output word valid.
	input  wire logic               out_ready_in, // Drain side takes the word.
	output logic [WIDTH-1:0]        out_data_out, // Output word.
	output logic [`DSI_LEVEL_W-1:0] level_out     // Words held in total.
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]   mem [DEPTH];
	logic [AW-1:0]      wr_ptr_q;
	logic [AW-1:0]      rd_ptr_q;
	logic [AW:0]        count_q;
	logic               out_valid_q;
	logic [WIDTH-1:0]   out_data_q;
	logic               push;
	logic               pop;

	// Handshakes on both sides; the output register refills whenever it empties.
	assign in_ready_out  = (count_q != DEPTH[AW:0]);
	assign push          = in_valid_in && in_ready_out && !flush_in;
	assign pop           = (count_q != '0) && (!out_valid_q || out_ready_in) && !flush_in;
	assign out_valid_out = out_valid_q;
	assign out_data_out  = out_data_q;
	assign level_out     = `DSI_LEVEL_W'(count_q) + {{(`DSI_LEVEL_W-1){1'b0}}, out_valid_q};

	// Storage array.
	always_ff @(posedge clock_in)
	begin
		if (push)
		begin
			mem[wr_ptr_q] <= in_data_in;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in || flush_in)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			end
			if (pop)
			begin
				rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
			end
			count_q <= (AW+1)'(count_q + push - pop);
		end
	end

	// Output register.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in || flush_in)
		begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end
		else if (pop)
		begin
			out_valid_q <= 1'b1;
			out_data_q  <= mem[rd_ptr_q];
		end
		else if (out_ready_in)
		begin
			out_valid_q <= 1'b0;
		end
	end

endmodule

// >>> src/dsi_port.sv
// Holds the digital sample input port of a dual-channel converter: pin synchronisers,
// clock source selection, sample capture, sync strobe handling, lock pin and registers.
// Assumes pins come from outside the clock domain and software uses a plain register port.
`timescale 1ns/1ns
`include "dsi_cfg.svh"

// Notes on behaviour
// - PLL and dual modes latch FIFO on input-rate clock.
// - External mode latches FIFO on input-rate clock.
// - FIFO disabled ignores the input-rate clock.
// - Sample clock used in external/dual, ignored PLL.
// - Channel A bus, optional bit reversal.
// - Channel B bus, optional bit reversal.
// - Sync strobe initialises oscillator, mixer, divider, FIFO.
// - Lock pin shows lock, internal or input clock.
// - Low reset clears all logic; control and divider load 0x784 and 0x04, FIFO storage is not reset.
module dsi_port
	import dsi_pkg::*;
(
	input  wire logic                     clock_in,                 // 50 MHz system clock.
	input  wire logic                     rst_n_in,                 // Chip reset, active low.
	input  wire logic                     input_rate_clock_pin_in,  // Input-rate clock.
	input  wire logic                     input_rate_clock_pin_n_in,// Its complement.
	input  wire logic                     sample_clock_pin_in,      // Sample clock.
	input  wire logic                     sample_clock_pin_n_in,    // Its complement.
	input  wire logic [`DSI_SAMPLE_W-1:0] chan_a_sample_bus_in,     // Channel A bus.
	input  wire logic [`DSI_SAMPLE_W-1:0] chan_b_sample_bus_in,     // Channel B bus.
	input  wire logic                     b_marker_in,              // B-sample marker.
	input  wire logic                     sync_strobe_in,           // Synchronisation strobe.
	input  wire logic                     pll_locked_in,            // PLL lock level.
	input  wire logic [`DSI_ADDR_W-1:0]   reg_addr_in,              // Register address.
	input  wire logic [15:0]              reg_wdata_in,             // Register write data.
	input  wire logic                     reg_wr_in,                // Write strobe.
	input  wire logic                     reg_rd_in,                // Read strobe.
	output logic [15:0]                   reg_rdata_out,            // Read data, next cycle.
	output dsi_sample_t                   samp_out,                 // Buffered sample pair.
	output logic                          samp_valid_out,           // Sample pair valid.
	input  wire logic                     samp_ready_in,            // Consumer takes it.
	output logic                          lock_indicator_out,       // Lock indicator pin.
	output logic                          nco_init_out,             // Oscillator init pulse.
	output logic                          mixer_init_out,           // Coarse mixer init pulse.
	output logic                          divider_init_out          // Divider init pulse.
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	dsi_pins_t              pins_s1_q;
	dsi_pins_t              pins_s2_q;
	dsi_pins_t              pins_s3_q;
	logic [3:0]             lvl_q;
	logic [3:0]             lvl_d;
	logic [3:0]             cand_s2;
	logic [3:0]             cand_s3;
	logic                   ir_rise;
	logic                   sc_rise;
	logic                   sync_rise;
	dsi_ctrl_t              ctrl_q;
	logic [`DSI_DIV_W-1:0]  div_q;
	logic [`DSI_DIV_W-1:0]  div_cnt_q;
	logic                   div_tick;
	logic                   int_clk_q;
	logic                   cap_go;
	dsi_sample_t            word_d;
	logic                   fifo_ready;
	logic                   fifo_flush;
	logic [`DSI_LEVEL_W-1:0] fifo_level;
	logic                   ovf_q;
	logic                   ovf_clr;
	logic [15:0]            rdata_q;
	logic                   lock_q;
	logic                   nco_q;
	logic                   mix_q;
	logic                   divi_q;

	default clocking dflt_cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	// Reverses the bit order of one sample bus.
	function automatic logic [`DSI_SAMPLE_W-1:0] rev16(input logic [`DSI_SAMPLE_W-1:0] v);
		logic [`DSI_SAMPLE_W-1:0] r;
		r = '0;
		for (int i = 0; i < `DSI_SAMPLE_W; i++)
		begin
			r[i] = v[`DSI_SAMPLE_W-1-i];
		end
		return r;
	endfunction

	// Turns a differential pair into a single level.
	function automatic logic diff_level(input logic p, input logic n);
		return p && !n;
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************

	// Three flops on every pin; data and clocks see the same delay, so they stay aligned.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			pins_s3_q <= '0;
		end
		else
		begin
			pins_s1_q <= '{ir_p: input_rate_clock_pin_in, ir_n: input_rate_clock_pin_n_in,
			               sc_p: sample_clock_pin_in, sc_n: sample_clock_pin_n_in,
			               sync: sync_strobe_in, lock: pll_locked_in, marker: b_marker_in,
			               a: chan_a_sample_bus_in, b: chan_b_sample_bus_in};
			pins_s2_q <= pins_s1_q;
			pins_s3_q <= pins_s2_q;
		end
	end

	// A level change counts once the second and third stages agree.
	assign cand_s2 = {diff_level(pins_s2_q.ir_p, pins_s2_q.ir_n),
	                  diff_level(pins_s2_q.sc_p, pins_s2_q.sc_n), pins_s2_q.sync, pins_s2_q.lock};
	assign cand_s3 = {diff_level(pins_s3_q.ir_p, pins_s3_q.ir_n),
	                  diff_level(pins_s3_q.sc_p, pins_s3_q.sc_n), pins_s3_q.sync, pins_s3_q.lock};
	assign lvl_d   = (~(cand_s2 ^ cand_s3) & cand_s3) | ((cand_s2 ^ cand_s3) & lvl_q);
	assign ir_rise   = lvl_d[3] && !lvl_q[3];
	assign sc_rise   = lvl_d[2] && !lvl_q[2];
	assign sync_rise = lvl_d[1] && !lvl_q[1];

	// Confirmed pin levels.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			lvl_q <= 4'h0;
		end
		else
		begin
			lvl_q <= lvl_d;
		end
	end

	// ****************************************************************
	// Internal clock divider
	// ****************************************************************

	assign div_tick = (div_cnt_q == div_q);

	// Divides the system clock into an internal rate; a sync strobe restarts it.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			div_cnt_q <= '0;
			int_clk_q <= 1'b0;
		end
		else if (sync_rise && ctrl_q.sync_div)
		begin
			div_cnt_q <= '0;
			int_clk_q <= 1'b0;
		end
		else if (div_tick)
		begin
			div_cnt_q <= '0;
			int_clk_q <= !int_clk_q;
		end
		else
		begin
			div_cnt_q <= `DSI_DIV_W'(div_cnt_q + 1'b1);
		end
	end

	// ****************************************************************
	// Capture clock selection and sample word
	// ****************************************************************

	// Picks the capture edge by clock mode; a disabled FIFO never looks at the input-rate clock.
	always_comb
	begin
		cap_go = 1'b0;
		unique case (ctrl_q.mode)
			DSI_MODE_PLL:
			begin
				cap_go = ctrl_q.fifo_en ? ir_rise : div_tick;
			end
			DSI_MODE_EXT:
			begin
				cap_go = ctrl_q.fifo_en ? ir_rise : sc_rise;
			end
			DSI_MODE_DUAL:
			begin
				cap_go = ctrl_q.fifo_en ? ir_rise : sc_rise;
			end
			default:
			begin
				cap_go = ctrl_q.fifo_en ? ir_rise : div_tick;
			end
		endcase
	end

	// Both buses and the marker come from the same synchroniser stage in the same cycle.
	always_comb
	begin
		word_d.a      = ctrl_q.a_rev ? rev16(pins_s3_q.a) : pins_s3_q.a;
		word_d.b      = ctrl_q.b_rev ? rev16(pins_s3_q.b) : pins_s3_q.b;
		word_d.marker = ctrl_q.marker_en && pins_s3_q.marker;
	end

	assign fifo_flush = sync_rise && ctrl_q.sync_fifo;

	// Input buffer; a full buffer drops the sample and raises the overflow flag.
	dsi_fifo #(
		.WIDTH ($bits(dsi_sample_t)),
		.DEPTH (`DSI_FIFO_DEPTH)
	) u_fifo (
		.clock_in      (clock_in),
		.rst_n_in      (rst_n_in),
		.flush_in      (fifo_flush),
		.in_valid_in   (cap_go),
		.in_ready_out  (fifo_ready),
		.in_data_in    (word_d),
		.out_valid_out (samp_valid_out),
		.out_ready_in  (samp_ready_in),
		.out_data_out  (samp_out),
		.level_out     (fifo_level)
	);

	// Sticky overflow; a new loss wins over a clear in the same cycle.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			ovf_q <= 1'b0;
		end
		else if (cap_go && !fifo_ready && !fifo_flush)
		begin
			ovf_q <= 1'b1;
		end
		else if (ovf_clr)
		begin
			ovf_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Sync strobe pulses and lock pin
	// ****************************************************************

	// One-cycle init pulses for the circuits selected in the control register.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			nco_q  <= 1'b0;
			mix_q  <= 1'b0;
			divi_q <= 1'b0;
		end
		else
		begin
			nco_q  <= sync_rise && ctrl_q.sync_nco;
			mix_q  <= sync_rise && ctrl_q.sync_mix;
			divi_q <= sync_rise && ctrl_q.sync_div;
		end
	end

	// Lock pin source: input-rate clock in external mode, lock level or internal clock otherwise.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			lock_q <= 1'b0;
		end
		else if (ctrl_q.mode == DSI_MODE_EXT)
		begin
			lock_q <= lvl_q[3];
		end
		else if (ctrl_q.lock_clk_sel)
		begin
			lock_q <= int_clk_q;
		end
		else
		begin
			lock_q <= lvl_q[0];
		end
	end

	assign nco_init_out       = nco_q;
	assign mixer_init_out     = mix_q;
	assign divider_init_out   = divi_q;
	assign lock_indicator_out = lock_q;

	// ****************************************************************
	// Register port
	// ****************************************************************

	assign ovf_clr = reg_wr_in && (reg_addr_in == `DSI_REG_STATUS) && reg_wdata_in[`DSI_OVF_BIT];

	// Writable registers; reset returns every control to its default.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_q <= `DSI_CTRL_RST;
			div_q  <= `DSI_DIV_RST;
		end
		else if (reg_wr_in && reg_addr_in == `DSI_REG_CTRL)
		begin
			ctrl_q <= reg_wdata_in[`DSI_CTRL_W-1:0];
		end
		else if (reg_wr_in && reg_addr_in == `DSI_REG_DIV)
		begin
			div_q <= reg_wdata_in[`DSI_DIV_W-1:0];
		end
	end

	// Read data stand for the one cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			rdata_q <= 16'h0000;
		end
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				`DSI_REG_CTRL:   rdata_q <= 16'(ctrl_q);
				`DSI_REG_STATUS: rdata_q <= {6'h00, fifo_level, lvl_q[0], ovf_q, 1'b0, ctrl_q.mode};
				`DSI_REG_DIV:    rdata_q <= 16'(div_q);
				default:         rdata_q <= 16'h0000;
			endcase
		end
		else
		begin
			rdata_q <= 16'h0000;
		end
	end

	assign reg_rdata_out = rdata_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	a_pll_dual_latch: assert property (ctrl_q.mode != DSI_MODE_EXT && ctrl_q.fifo_en
		&& ir_rise && fifo_ready && !fifo_flush |=> fifo_level != '0
		&& ($past(fifo_level) != '0 || fifo_level == `DSI_LEVEL_W'(1)))
		else $error("input-rate edge did not load a sample");
	a_ext_fifo_latch: assert property (ctrl_q.mode == DSI_MODE_EXT && ctrl_q.fifo_en
		|-> cap_go == ir_rise)
		else $error("external mode FIFO not latched on input-rate clock");
	a_fifo_off_ignore: assert property (!ctrl_q.fifo_en && ir_rise && !sc_rise
		&& !div_tick |-> !cap_go)
		else $error("input-rate clock used with FIFO disabled");
	a_pll_sc_ignore: assert property (ctrl_q.mode == DSI_MODE_PLL && sc_rise && !ir_rise
		&& !div_tick |-> !cap_go)
		else $error("sample clock used in PLL mode");
	a_chan_a_order: assert property (cap_go && fifo_ready && $past(cap_go) == 1'b0
		&& fifo_level == '0 && !samp_valid_out && !fifo_flush
		##1 !samp_valid_out ##1 1'b1
		|-> samp_out.a == (ctrl_q.a_rev ? rev16($past(pins_s3_q.a, 2)) : $past(pins_s3_q.a, 2)))
		else $error("channel A word order wrong");
	a_chan_b_order: assert property (cap_go && !ctrl_q.b_rev |-> word_d.b == pins_s3_q.b
		&& word_d.b == $past(pins_s2_q.b))
		else $error("channel B word order wrong");
	a_sync_pulse: assert property (sync_rise && ctrl_q.sync_nco |=> nco_init_out
		##1 !nco_init_out)
		else $error("oscillator init pulse not one cycle");
	a_lock_source: assert property (ctrl_q.mode == DSI_MODE_PLL && !ctrl_q.lock_clk_sel
		&& $stable(ctrl_q) |=> lock_indicator_out == $past(lvl_q[0]))
		else $error("lock pin does not follow lock level");
	a_reset_clear: assert property (@(posedge clock_in) disable iff (1'b0)
		!rst_n_in |=> !samp_valid_out && !nco_init_out && ctrl_q == `DSI_CTRL_RST)
		else $error("reset did not clear the port");
	a_same_edge: assert property (cap_go && ctrl_q.marker_en |-> word_d.marker
		== pins_s3_q.marker && word_d.a[0] == (ctrl_q.a_rev ? pins_s3_q.a[15] : pins_s3_q.a[0]))
		else $error("marker and buses not taken together");

endmodule

// >>> tb/dsi_source.sv
// Holds a behavioural sample source: clock pins, sample buses, marker, sync strobe, lock level.
// Assumes the bench calls its tasks and that every pin is sampled on clock_in.
`timescale 1ns/1ns

module dsi_source
(
	input  wire logic clock_in,   // System clock.
	output logic      ir_out,     // Input-rate clock.
	output logic      ir_n_out,   // Its complement.
	output logic      sc_out,     // Sample clock.
	output logic      sc_n_out,   // Its complement.
	output logic [15:0] a_out,    // Channel A bus.
	output logic [15:0] b_out,    // Channel B bus.
	output logic      marker_out, // B-sample marker.
	output logic      sync_out,   // Sync strobe.
	output logic      lock_out    // PLL lock level.
);
	// The complements always mirror the true pins.
	assign ir_n_out = ~ir_out;
	assign sc_n_out = ~sc_out;

	// Clocks stand low outside frames.
	initial
	begin
		ir_out = 1'b0;
		sc_out = 1'b0;
		a_out = 16'h0000;
		b_out = 16'h0000;
		marker_out = 1'b0;
		sync_out = 1'b0;
		lock_out = 1'b0;
	end

	// One sample pair on one rising clock edge; data flip once the clock falls.
	task automatic send(input logic [15:0] a, input logic [15:0] b, input logic m,
		input logic sel);
		@(posedge clock_in);
		a_out <= a;
		b_out <= b;
		marker_out <= m;
		if (sel)
			sc_out <= 1'b1;
		else
			ir_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		ir_out <= 1'b0;
		sc_out <= 1'b0;
		a_out <= ~a;
		b_out <= ~b;
		marker_out <= ~m;
		repeat (2) @(posedge clock_in);
	endtask

	// A strobe pulse long enough to be confirmed, then low again.
	task automatic pulse_sync();
		@(posedge clock_in);
		sync_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		sync_out <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask

	// Static levels of the lock input and of the input-rate pin.
	task automatic set_lock(input logic v);
		@(posedge clock_in);
		lock_out <= v;
	endtask

	task automatic set_ir(input logic v);
		@(posedge clock_in);
		ir_out <= v;
	endtask
endmodule

// >>> tb/tb_top.sv
// Holds the self-checking bench of the sample input port with a queue model of the FIFO.
// Assumes dsi_pkg, dsi_port, dsi_fifo and dsi_source are compiled first.
`timescale 1ns/1ns
`include "dsi_cfg.svh"

module tb_top;
	import dsi_pkg::*;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ir, ir_n, sc, sc_n, marker, sync, lock;
	logic [15:0] a, b, rd_v;
	logic [`DSI_ADDR_W-1:0] reg_addr_in = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic samp_ready_in = 1'b0;
	logic [15:0] reg_rdata_out;
	dsi_sample_t samp_out;
	logic samp_valid_out, lock_indicator_out, nco_init_out, mixer_init_out, divider_init_out;
	int errors = 0;
	int total_checks = 0;
	integer seed = 46105;
	int n_init[3] = '{0, 0, 0};
	bit stall = 1'b1;
	bit m_arev, m_brev, m_men, m_fen;
	logic [1:0] m_mode;
	dsi_sample_t exp_q[$];

	dsi_port i_dsi_port (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.input_rate_clock_pin_in(ir), .input_rate_clock_pin_n_in(ir_n),
		.sample_clock_pin_in(sc), .sample_clock_pin_n_in(sc_n),
		.chan_a_sample_bus_in(a), .chan_b_sample_bus_in(b), .b_marker_in(marker),
		.sync_strobe_in(sync), .pll_locked_in(lock), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .samp_out(samp_out), .samp_valid_out(samp_valid_out),
		.samp_ready_in(samp_ready_in), .lock_indicator_out(lock_indicator_out),
		.nco_init_out(nco_init_out), .mixer_init_out(mixer_init_out),
		.divider_init_out(divider_init_out));

	dsi_source i_dsi_source (.clock_in(clock_in), .ir_out(ir), .ir_n_out(ir_n), .sc_out(sc),
		.sc_n_out(sc_n), .a_out(a), .b_out(b), .marker_out(marker), .sync_out(sync),
		.lock_out(lock));

	// ****************************************************************
	// Clock, consumer, monitors and checking
	// ****************************************************************
	always #10 clock_in = ~clock_in;

	// The consumer stalls on request, otherwise takes words at random.
	always @(posedge clock_in)
		samp_ready_in <= stall ? 1'b0 : seed_bit();

	function automatic logic seed_bit();
		return 1'($random(seed));
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Every word taken by the consumer is compared with the head of the model queue.
	always @(posedge clock_in)
		if (rst_n_in && samp_valid_out === 1'b1 && samp_ready_in === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(samp_out, 33'h1_ffff_ffff);
			else
				check(samp_out, exp_q.pop_front());
		end

	// Init pulses are counted so their number can be compared.
	always @(posedge clock_in)
	begin
		if (nco_init_out === 1'b1) n_init[0]++;
		if (mixer_init_out === 1'b1) n_init[1]++;
		if (divider_init_out === 1'b1) n_init[2]++;
	end

	function automatic logic [15:0] rev(input logic [15:0] v);
		logic [15:0] r;
		for (int i = 0; i < 16; i++) r[i] = v[15 - i];
		return r;
	endfunction

	// ****************************************************************
	// Bus and stimulus tasks
	// ****************************************************************
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clock_in);
		reg_addr_in <= ad;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] ad, input logic [15:0] exp);
		@(posedge clock_in);
		reg_addr_in <= ad;
		reg_rd_in <= 1'b1;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		#1 rd_v = reg_rdata_out;
		check(33'(rd_v), 33'(exp));
	endtask

	// Control with all four sync targets on and the lock pin on lock or input clock.
	task automatic set_ctrl(input logic [1:0] md, input bit fen, ar, br, men);
		m_mode = md;
		m_fen = fen;
		m_arev = ar;
		m_brev = br;
		m_men = men;
		wr(`DSI_REG_CTRL, 16'({4'hf, 1'b0, men, br, ar, fen, md}));
	endtask

	// Sends one random pair; the model keeps it if this clock captures and there is room.
	task automatic put(input bit sel);
		logic [15:0] ra, rb;
		logic m;
		dsi_sample_t e;
		ra = 16'($random(seed));
		rb = 16'($random(seed));
		m = 1'($random(seed));
		e.a = m_arev ? rev(ra) : ra;
		e.b = m_brev ? rev(rb) : rb;
		e.marker = m & m_men;
		if ((sel ? (!m_fen && m_mode != 2'd0) : m_fen) && exp_q.size() < 17)
			exp_q.push_back(e);
		i_dsi_source.send(ra, rb, m, sel);
	endtask

	task automatic drain(input string name);
		stall = 1'b0;
		for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clock_in);
		repeat (4) @(posedge clock_in);
		check(33'(exp_q.size()), 33'h0);
		$display("test %s done", name);
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog far beyond the thousand or so cycles the tests need.
	initial
	begin
		repeat (30000) @(posedge clock_in);
		errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		check(33'({samp_valid_out, lock_indicator_out}), 33'h0);
		rdchk(`DSI_REG_CTRL, 16'h0784);
		rdchk(`DSI_REG_DIV, 16'h0004);
		rdchk(`DSI_REG_STATUS, 16'h0000);
		wr(4'h2, 16'hffff);
		rdchk(4'h2, 16'h0000);
		rdchk(`DSI_REG_CTRL, 16'h0784);
		wr(`DSI_REG_DIV, 16'h00a5);
		rdchk(`DSI_REG_DIV, 16'h00a5);
		$display("test reset done");
		set_ctrl(2'd0, 1, 0, 0, 1);
		stall = 1'b0;
		for (int i = 0; i < 8; i++) put(0);
		for (int i = 0; i < 3; i++) put(1);
		drain("pll");
		for (int r = 0; r < 4; r++)
		begin
			set_ctrl(2'd0, 1, r[0], r[1], r[0] ^ r[1]);
			for (int i = 0; i < 4; i++) put(0);
		end
		drain("order");
		set_ctrl(2'd1, 1, 0, 0, 1);
		for (int i = 0; i < 4; i++) put(0);
		put(1);
		drain("ext");
		exp_q.push_back({marker, b, a});
		i_dsi_source.set_ir(1'b1);
		repeat (6) @(posedge clock_in);
		check(33'(lock_indicator_out), 33'h1);
		i_dsi_source.set_ir(1'b0);
		repeat (6) @(posedge clock_in);
		check(33'(lock_indicator_out), 33'h0);
		for (int md = 1; md < 3; md++)
		begin
			set_ctrl(2'(md), 0, 0, 1, 1);
			for (int i = 0; i < 4; i++) put(1);
			for (int i = 0; i < 3; i++) put(0);
			drain("no fifo clock");
			rdchk(`DSI_REG_STATUS, 16'(md));
		end
		set_ctrl(2'd2, 1, 1, 0, 1);
		for (int i = 0; i < 3; i++) put(0);
		put(1);
		drain("dual");
		set_ctrl(2'd0, 1, 0, 0, 0);
		i_dsi_source.set_lock(1'b1);
		repeat (8) @(posedge clock_in);
		check(33'(lock_indicator_out), 33'h1);
		rdchk(`DSI_REG_STATUS, 16'h0010);
		i_dsi_source.set_lock(1'b0);
		repeat (8) @(posedge clock_in);
		check(33'(lock_indicator_out), 33'h0);
		wr(`DSI_REG_DIV, 16'h0003);
		wr(`DSI_REG_CTRL, 16'h07c4);
		repeat (264) @(posedge clock_in);
		rd_v[0] = lock_indicator_out;
		repeat (4) @(posedge clock_in);
		check(33'(lock_indicator_out), 33'(!rd_v[0]));
		$display("test lock done");
		stall = 1'b1;
		for (int i = 0; i < 20; i++) put(0);
		rdchk(`DSI_REG_STATUS, 16'h0228);
		wr(`DSI_REG_STATUS, 16'h0004);
		rdchk(`DSI_REG_STATUS, 16'h0220);
		drain("full");
		rdchk(`DSI_REG_STATUS, 16'h0000);
		stall = 1'b1;
		for (int i = 0; i < 3; i++) put(0);
		i_dsi_source.pulse_sync();
		repeat (2) @(posedge clock_in);
		for (int k = 0; k < 3; k++) check(33'(n_init[k]), 33'h1);
		exp_q.delete();
		rdchk(`DSI_REG_STATUS, 16'h0000);
		wr(`DSI_REG_CTRL, 16'h0004);
		for (int i = 0; i < 2; i++) put(0);
		i_dsi_source.pulse_sync();
		repeat (2) @(posedge clock_in);
		for (int k = 0; k < 3; k++) check(33'(n_init[k]), 33'h1);
		rdchk(`DSI_REG_STATUS, 16'h0040);
		drain("sync");
		give_verdict();
	end
endmodule
